// [cocd_pkg.sv]
// shared constants and types for the option-word decoder
package cocd_pkg;

   // configuration store geometry
   localparam int CFG_W = 13;
   localparam int CFG_WORDS = 3;
   localparam int CUST_ID_W = 2 * CFG_W;

   // option word 0 field positions
   localparam int OPT_PERIOD_BIT = 8;
   localparam int OPT_WDT_OFF_BIT = 7;
   localparam int OPT_BRANCH_BIT = 6;
   localparam int OPT_CLKSRC_BIT = 4;
   localparam int OPT_POWER_BIT = 3;
   localparam int OPT_WP_LSB = 0;
   localparam int OPT_WP_W = 3;
   localparam logic [2:0] WP_OPEN_CODE = 3'h7;

   // instruction-cycle lengths in oscillator periods
   localparam logic [2:0] PERIOD_SHORT = 3'h2;
   localparam logic [2:0] PERIOD_LONG = 3'h4;

   // register byte offsets on the bus
   localparam int ADR_W = 8;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_CYCLES = 8'h08;
   localparam logic [7:0] ADDR_OPTION = 8'h0c;

   // control register layout and reset value
   localparam int CTRL_W = 3;
   localparam int CTRL_SEQ_RUN_BIT = 0;
   localparam int CTRL_TICK_RUN_BIT = 1;
   localparam int CTRL_CNT_CLR_BIT = 2;
   localparam logic [2:0] CTRL_RESET = 3'h3;

   // status register layout
   localparam int STAT_LOADED_BIT = 0;
   localparam int STAT_PHASE_LSB = 4;
   localparam int CYCLE_CNT_W = 16;

   // decoded options as seen by the core
   typedef struct packed {
      logic period_four;
      logic watchdog_en;
      logic branch_two;
      logic xtal_mode;
      logic power_high;
      logic protect_en;
   } cocd_opt_t;

   // loader sequence
   typedef enum logic [1:0] {
      ST_LOAD = 2'b00,
      ST_RUN = 2'b01
   } cocd_state_t;

endpackage : cocd_pkg

// [cocd_option_decode.sv]
// The placing of the registers and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps

module cocd_option_decode
   import cocd_pkg::*;
#(
   parameter int CNT_W = CYCLE_CNT_W
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [CFG_W-1:0] cfg_word0_i,
   input wire logic [CFG_W-1:0] cfg_word1_i,
   input wire logic [CFG_W-1:0] cfg_word2_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   output cocd_opt_t opt_o,
   output logic [CUST_ID_W-1:0] customer_id_o,
   output logic instr_cycle_stb_o,
   output logic tick_src_stb_o
);

   // captured options and identity
   cocd_opt_t opt_q;
   logic [CUST_ID_W-1:0] cust_id_q;
   cocd_state_t state_q;
   cocd_state_t state_d;

   // sequencer state
   logic [2:0] phase_q;
   logic [2:0] phase_d;
   logic [2:0] period_len;
   logic phase_wrap;
   logic seq_active;
   logic [CNT_W-1:0] cycles_q;
   logic [CNT_W-1:0] cycles_d;
   logic instr_stb_q;
   logic tick_stb_q;

   // bus registers
   logic [CTRL_W-1:0] ctrl_q;
   logic [CTRL_W-1:0] ctrl_d;
   logic ack_q;
   logic err_q;
   logic [31:0] dat_q;

   // option word decode, used only while reset is asserted
   cocd_opt_t opt_decoded;
   logic [CUST_ID_W-1:0] cust_id_decoded;

   // one wire per option field, gathered into the struct below
   logic pick_period;
   logic pick_wdt_en;
   logic pick_branch;
   logic pick_xtal;
   logic pick_power;
   logic wp_open;

   // bits 12..9 and bit 5 of word 0 are simply not looked at
   // period select: low two periods, high four
   cocd_bit_pick #(
      .POS(OPT_PERIOD_BIT),
      .INVERT(1'b0)
   ) u_pick_period (
      .word_i(cfg_word0_i),
      .bit_o(pick_period)
   );

   // watchdog select is active low, so this pick inverts it
   cocd_bit_pick #(
      .POS(OPT_WDT_OFF_BIT),
      .INVERT(1'b1)
   ) u_pick_wdt (
      .word_i(cfg_word0_i),
      .bit_o(pick_wdt_en)
   );

   // jump and call length
   cocd_bit_pick #(
      .POS(OPT_BRANCH_BIT),
      .INVERT(1'b0)
   ) u_pick_branch (
      .word_i(cfg_word0_i),
      .bit_o(pick_branch)
   );

   // high selects crystal or an external clock on the crystal input
   cocd_bit_pick #(
      .POS(OPT_CLKSRC_BIT),
      .INVERT(1'b0)
   ) u_pick_xtal (
      .word_i(cfg_word0_i),
      .bit_o(pick_xtal)
   );

   // drive power level
   cocd_bit_pick #(
      .POS(OPT_POWER_BIT),
      .INVERT(1'b0)
   ) u_pick_power (
      .word_i(cfg_word0_i),
      .bit_o(pick_power)
   );

   // protection is lifted by one code only, so a half-programmed word stays safe
   cocd_code_match #(
      .LSB(OPT_WP_LSB),
      .W(OPT_WP_W),
      .CODE(WP_OPEN_CODE)
   ) u_match_wp (
      .word_i(cfg_word0_i),
      .match_o(wp_open)
   );

   assign opt_decoded = {pick_period, pick_wdt_en, pick_branch, pick_xtal, pick_power, ~wp_open};

   // word 2 forms the upper half, word 1 the lower half of the id
   assign cust_id_decoded = {cfg_word2_i, cfg_word1_i};

   // capture only under reset, so a glitching store cannot move options mid-run
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         opt_q <= opt_decoded;
      end
   end

   // the identity is captured alongside the options
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cust_id_q <= cust_id_decoded;
      end
   end

   // loader sequence: hold in load for the first enabled cycle after release
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_LOAD: begin
            state_d = ST_RUN;
         end
         ST_RUN: begin
            state_d = ST_RUN;
         end
         default: begin
            state_d = ST_LOAD;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_LOAD;
      end else if (ce_i) begin
         state_q <= state_d;
      end
   end

   // instruction-cycle length follows the captured period select
   assign period_len = opt_q.period_four ? PERIOD_LONG : PERIOD_SHORT;
   assign seq_active = (state_q == ST_RUN) && ctrl_q[CTRL_SEQ_RUN_BIT];
   assign phase_wrap = seq_active && (phase_q == (period_len - 3'h1));

   // phase counter within one instruction cycle
   always_comb begin
      phase_d = phase_q;
      if (!seq_active) begin
         phase_d = 3'h0;
      end else if (phase_wrap) begin
         phase_d = 3'h0;
      end else begin
         phase_d = phase_q + 3'h1;
      end
   end

   // instruction cycle counter, cleared by software through the control word
   always_comb begin
      cycles_d = cycles_q;
      if (ctrl_q[CTRL_CNT_CLR_BIT]) begin
         cycles_d = '0;
      end else if (phase_wrap) begin
         cycles_d = cycles_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // phase within the instruction cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_q <= 3'h0;
      end else if (ce_i) begin
         phase_q <= phase_d;
      end
   end

   // instruction cycle count
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cycles_q <= '0;
      end else if (ce_i) begin
         cycles_q <= cycles_d;
      end
   end

   // strobes are registered so the core sees clean pulses one enabled cycle long
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         instr_stb_q <= 1'b0;
      end else if (ce_i) begin
         instr_stb_q <= phase_wrap;
      end
   end

   // tick source shares the instruction divider: fosc/2 or fosc/4
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_stb_q <= 1'b0;
      end else if (ce_i) begin
         tick_stb_q <= phase_wrap && ctrl_q[CTRL_TICK_RUN_BIT];
      end
   end

   // bus decode
   logic bus_req;
   logic hit_ctrl;
   logic hit_status;
   logic hit_cycles;
   logic hit_option;
   logic hit_any;
   logic do_write;
   logic [31:0] rd_mux;
   logic [31:0] status_word;

   // a new request is seen only while no answer is standing
   assign bus_req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
   assign hit_ctrl = (wb_adr_i == ADDR_CTRL);
   assign hit_status = (wb_adr_i == ADDR_STATUS);
   assign hit_cycles = (wb_adr_i == ADDR_CYCLES);
   assign hit_option = (wb_adr_i == ADDR_OPTION);
   assign hit_any = hit_ctrl || hit_status || hit_cycles || hit_option;
   assign do_write = bus_req && wb_we_i && hit_ctrl && wb_sel_i[0];

   // status shows only loader and sequencer state, never the option fields
   assign status_word = {{(32-STAT_PHASE_LSB-3){1'b0}}, phase_q,
                         {(STAT_PHASE_LSB-1){1'b0}}, (state_q == ST_RUN)};

   // the option slot answers but is write-ignored and reads zero
   assign rd_mux = hit_ctrl ? {{(32-CTRL_W){1'b0}}, ctrl_q} :
                   hit_status ? status_word :
                   hit_cycles ? {{(32-CNT_W){1'b0}}, cycles_q} :
                   32'h0000_0000;

   // control: counter clear self-clears one cycle after it is written
   always_comb begin
      ctrl_d = ctrl_q;
      ctrl_d[CTRL_CNT_CLR_BIT] = 1'b0;
      if (do_write) begin
         ctrl_d = wb_dat_i[CTRL_W-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= CTRL_RESET;
      end else if (ce_i) begin
         ctrl_q <= ctrl_d;
      end
   end

   // single registered answer per request; unmapped addresses get err
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         err_q <= 1'b0;
      end else if (ce_i) begin
         ack_q <= bus_req && hit_any;
         err_q <= bus_req && !hit_any;
      end
   end

   // read data is kept until the next mapped read, so a slow master still sees it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= 32'h0000_0000;
      end else if (ce_i && bus_req && hit_any && !wb_we_i) begin
         dat_q <= rd_mux;
      end
   end

   // outputs
   assign wb_ack_o = ack_q;
   assign wb_err_o = err_q;
   assign wb_dat_o = dat_q;
   assign opt_o = opt_q;
   assign customer_id_o = cust_id_q;
   assign instr_cycle_stb_o = instr_stb_q;
   assign tick_src_stb_o = tick_stb_q;

endmodule : cocd_option_decode

// one option bit taken from a configuration word, optionally inverted
module cocd_bit_pick
   import cocd_pkg::*;
#(
   parameter int POS = 0,
   parameter bit INVERT = 1'b0
) (
   input wire logic [CFG_W-1:0] word_i,
   output logic bit_o
);

   // a plain wire: the capture flops sit in the parent
   assign bit_o = word_i[POS] ^ INVERT;

endmodule : cocd_bit_pick

// compares a field against a single code; every other value counts as a miss
module cocd_code_match
   import cocd_pkg::*;
#(
   parameter int LSB = 0,
   parameter int W = 3,
   parameter logic [W-1:0] CODE = '1
) (
   input wire logic [CFG_W-1:0] word_i,
   output logic match_o
);

   // whole-field compare, so a single stray bit keeps the match low
   assign match_o = (word_i[LSB +: W] == CODE);

endmodule : cocd_code_match

// [cocd_props.sv]
`timescale 1ns/1ps
module cocd_props
   import cocd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [CFG_W-1:0] cfg_word0_i,
   input wire logic [CFG_W-1:0] cfg_word1_i,
   input wire logic [CFG_W-1:0] cfg_word2_i,
   input wire cocd_opt_t opt_o,
   input wire logic [CUST_ID_W-1:0] customer_id_o,
   input wire logic instr_cycle_stb_o,
   input wire logic tick_src_stb_o
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge clk_i); endclocking
   // a frozen clock enable holds strobes, so spacing checks pause with it
   default disable iff (rst_i || !ce_i);
   // first running edge compares against the inputs seen at the last reset edge
   opt_hold_a: assert property (!$past(rst_i) |-> $stable(opt_o)) else $error("options moved");
   id_hold_a: assert property (!$past(rst_i) |-> $stable(customer_id_o)) else $error("id moved");
   id_load_a: assert property ($fell(rst_i) |-> customer_id_o == $past({cfg_word2_i, cfg_word1_i}))
      else $error("id load");
   wdt_pol_a: assert property ($fell(rst_i) |-> opt_o.watchdog_en == !$past(cfg_word0_i[7]))
      else $error("watchdog polarity");
   prot_code_a: assert property ($fell(rst_i) |-> opt_o.protect_en == ($past(cfg_word0_i[2:0]) != 3'h7))
      else $error("protect code");
   // strobe spacing only holds while the sequencer is never stopped over the bus
   short_cyc_a: assert property (instr_cycle_stb_o && !opt_o.period_four |=> !instr_cycle_stb_o ##1 instr_cycle_stb_o)
      else $error("short cycle");
   long_cyc_a: assert property (instr_cycle_stb_o && opt_o.period_four |=> !instr_cycle_stb_o [*3] ##1 instr_cycle_stb_o)
      else $error("long cycle");
   tick_src_a: assert property (tick_src_stb_o |-> instr_cycle_stb_o) else $error("tick source");
   cover property (instr_cycle_stb_o && opt_o.period_four);
   cover property (instr_cycle_stb_o && !opt_o.period_four);
   cover property ($fell(rst_i) && !opt_o.protect_en);
endmodule : cocd_props

bind cocd_option_decode cocd_props u_cocd_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cfg_word0_i(cfg_word0_i),
   .cfg_word1_i(cfg_word1_i), .cfg_word2_i(cfg_word2_i), .opt_o(opt_o), .customer_id_o(customer_id_o),
   .instr_cycle_stb_o(instr_cycle_stb_o), .tick_src_stb_o(tick_src_stb_o));

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
   import cocd_pkg::*;
   logic clk_i = 0;
   logic rst_i = 1;
   logic [12:0] w0 = 0, w1 = 0, w2 = 0;
   logic [7:0] adr = 0;
   logic [31:0] rdat;
   logic we = 0, cyc = 0, stb = 0, ack, err, istb, tstb;
   logic ce = 1;
   logic [31:0] wdat = 0;
   logic [3:0] sel = 4'hf;
   cocd_opt_t opt;
   logic [25:0] cid;
   int n_errors = 0;
   int n_checks = 0;
   // 200 mhz
   always #2.5 clk_i = ~clk_i;
   cocd_option_decode u_cocd_option_decode (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cfg_word0_i(w0),
      .cfg_word1_i(w1), .cfg_word2_i(w2), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
      .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
      .opt_o(opt), .customer_id_o(cid), .instr_cycle_stb_o(istb), .tick_src_stb_o(tstb));
   task chk(string s, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", s, e, g);
         n_errors++;
      end
   endtask : chk
   task final_report;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : final_report
   // classic cycle, held until ack or err is sampled; only the watchdog ends a hang
   task wb(logic [7:0] a, logic w, logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge clk_i);
      adr <= a;
      we <= w;
      wdat <= d;
      cyc <= 1;
      stb <= 1;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1 && err !== 1'b1);
      q = rdat;
      e = err;
      cyc <= 0;
      stb <= 0;
   endtask : wb
   // reset with a given option word, then move words 0 and 1 and check that the options hold
   task t_decode(logic [12:0] a);
      logic [31:0] e;
      int n;
      @(posedge clk_i);
      w0 <= a;
      w1 <= ~a;
      w2 <= a ^ 13'h0aaa;
      rst_i <= 1;
      repeat (6) @(posedge clk_i);
      rst_i <= 0;
      e = {26'h0, a[8], ~a[7], a[6], a[4], a[3], a[2:0] != WP_OPEN_CODE};
      chk("opt", e, {26'h0, opt});
      chk("cid", {6'h0, a ^ 13'h0aaa, ~a}, {6'h0, cid});
      w0 <= ~a;
      w1 <= a;
      repeat (12) @(posedge clk_i);
      chk("opt held", e, {26'h0, opt});
      n = 0;
      while (istb !== 1'b1 && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (istb !== 1'b1 && n < 20);
      chk("period", a[8] ? 4 : 2, n);
      chk("tick", 1, tstb);
      $display("decode %h done", a);
   endtask : t_decode
   // option slot has no bus path; unmapped place is refused
   task t_bus;
      logic [31:0] q;
      logic e;
      wb(ADDR_OPTION, 1, 32'hffffffff, q, e);
      chk("opt write err", 0, e);
      wb(ADDR_OPTION, 0, 32'h0, q, e);
      chk("opt slot", 0, q);
      wb(ADDR_CTRL, 0, 32'h0, q, e);
      chk("ctrl", CTRL_RESET, q);
      wb(8'h10, 0, 32'h0, q, e);
      chk("unmapped", 1, e);
      $display("bus done");
   endtask : t_bus
   // control bits: byte gate, tick gating, clear against a running count, clock-enable freeze
   task t_ctrl;
      logic [31:0] q;
      logic e;
      int k;
      int hits;
      sel <= 4'he;
      wb(ADDR_CTRL, 1, 32'h0, q, e);
      sel <= 4'hf;
      wb(ADDR_CTRL, 0, 32'h0, q, e);
      chk("sel gate", CTRL_RESET, q);
      wb(ADDR_CTRL, 1, 32'h1, q, e);
      wb(ADDR_CTRL, 0, 32'h0, q, e);
      chk("ctrl rd", 32'h1, q);
      hits = 0;
      k = 0;
      repeat (8) begin
         @(posedge clk_i);
         if (istb === 1'b1) hits++;
         if (tstb !== 1'b0) k++;
      end
      chk("strobes", 4, hits);
      chk("tick off", 0, k);
      // align to a strobe so the clear lands on a counting edge
      while (istb !== 1'b1) @(posedge clk_i);
      wb(ADDR_CTRL, 1, 32'h5, q, e);
      wb(ADDR_CYCLES, 0, 32'h0, q, e);
      chk("cycles clr", 32'h0, q);
      wb(ADDR_CYCLES, 0, 32'h0, q, e);
      chk("cycles run", 32'h2, q);
      wb(ADDR_STATUS, 0, 32'h0, q, e);
      chk("status", 32'h11, q);
      while (istb !== 1'b1) @(posedge clk_i);
      ce <= 0;
      k = 0;
      repeat (10) begin
         @(posedge clk_i);
         if (istb !== 1'b0 || tstb !== 1'b0) k++;
      end
      ce <= 1;
      chk("ce freeze", 0, k);
      hits = 0;
      repeat (8) begin
         @(posedge clk_i);
         if (istb === 1'b1) hits++;
      end
      chk("ce resume", 4, hits);
      $display("ctrl done");
   endtask : t_ctrl
   logic [12:0] tv [5] = '{13'h0000, 13'h1fff, 13'h1e07, 13'h0158, 13'h0086};
   initial begin
      foreach (tv[i]) t_decode(tv[i]);
      t_bus;
      t_ctrl;
      final_report;
   end
   // hang guard
   initial begin
      #100000;
      $display("ERROR watchdog expected done seen timeout");
      n_errors++;
      final_report;
   end
endmodule : testbench
